/* File: design/bsq_defs.svh */
// constants of the buck start-up and fault sequencer
`ifndef BSQ_DEFS_SVH
`define BSQ_DEFS_SVH
`define BSQ_ADR_CTRL    8'h00
`define BSQ_ADR_STATUS  8'h04
`define BSQ_CTRL_SHDN   0
`define BSQ_CTRL_NOSYNC 1
`define BSQ_CNT_W       16
`define BSQ_CLK_NS      40
`define BSQ_BLANK_NS    160
`define BSQ_HICCUP      4096
`define BSQ_PG_DELAY    256
`define BSQ_STEP1_N     32
`define BSQ_STEP2_N     16
`define BSQ_STEP3_N     8
`define BSQ_FREE_DIV    42
`define BSQ_SYNC_TMO    256
`endif

/* File: design/bsq_pkg.sv */
// types of the buck start-up and fault sequencer
`include "bsq_defs.svh"
package bsq_pkg;
  typedef logic [`BSQ_CNT_W-1:0] bsq_cnt_t;
  typedef enum logic [2:0] {
    ST_OFF, ST_SS_WAIT, ST_PREBIAS, ST_RUN,
    ST_HICCUP, ST_THERMAL, ST_OV_HOLD, ST_OV_LATCH
  } bsq_state_t;
  // comparator outputs and pin levels, all asynchronous to clk_i
  typedef struct packed {
    logic pwm;     // loop asks for the high-side pulse
    logic vcc_ok;  // bias supply above its lockout
    logic en_ok;   // enable above its lockout
    logic ss_live; // soft-start node above 0.3 V
    logic ss_pg;   // soft-start node at or above 2.1 V
    logic oc;      // current-limit sense below ground
    logic ov;      // output sense above 1.15 x reference
    logic pg_win;  // output sense inside the regulation window
    logic ot_hot;  // die above the thermal trip
    logic ot_cool; // die back below trip minus hysteresis
    logic sync;    // external frequency input level
    logic pg_pin;  // level seen on the power-good wire
  } bsq_cmp_t;
  // whole state of the sequencer
  typedef struct packed {
    bsq_state_t  state;
    logic [1:0]  step;
    bsq_cnt_t    pulse_cnt;
    bsq_cnt_t    hic_cnt;
    bsq_cnt_t    pg_cnt;
    bsq_cnt_t    phase;
    bsq_cnt_t    sync_age;
    bsq_cnt_t    ls_cnt;
    logic [3:0]  blank;
    logic        good;
    logic        overcurrent_latch;
    logic        ext_lock;
    logic        sync_d;
    logic        hs;
    logic        ls;
    logic        oe;
    logic        ssd;
    logic        shdn;
    logic        nosync;
    logic        ack;
    logic [31:0] rdat;
    bsq_cmp_t    meta;
    bsq_cmp_t    sy;
  } bsq_st_t;
endpackage

/* File: design/bsq_sequencer.sv */
// buck start-up and fault sequencer with wishbone registers
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bsq_defs.svh"
module bsq_sequencer #(
  parameter int unsigned FREE_DIV      = `BSQ_FREE_DIV,  // clk per free-running cycle
  parameter int unsigned HICCUP_CYCLES = `BSQ_HICCUP,    // switching cycles in hiccup
  parameter int unsigned PG_DELAY      = `BSQ_PG_DELAY,  // switching cycles of pg delay
  parameter int unsigned SYNC_TMO      = `BSQ_SYNC_TMO   // clk without edge = no sync
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire bsq_pkg::bsq_cmp_t cmp_i,      // raw comparator levels
  input  wire logic [7:0]       adr_i,
  input  wire logic [31:0]      dat_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic             we_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  output logic [31:0]           dat_o,
  output logic                  ack_o,
  output logic                  hs_en_o,     // high-side gate enable
  output logic                  ls_en_o,     // low-side gate enable
  output logic                  drv_oe_o,    // low puts both drivers in high-z
  output logic                  ss_dis_o,    // soft-start discharge switch
  output logic                  pgood_o,     // open-drain value, always low
  output logic                  pgood_oe_o   // high while pulling power-good low
);
  localparam int BLANK_CYC = (`BSQ_BLANK_NS + `BSQ_CLK_NS - 1) / `BSQ_CLK_NS;
  localparam logic [3:0] BLANK_LAST = 4'(BLANK_CYC);
  localparam bsq_pkg::bsq_cnt_t FREE_LAST = `BSQ_CNT_W'(FREE_DIV - 1);
  // the first tick in hiccup only closes the cycle already running, so it is not counted
  localparam bsq_pkg::bsq_cnt_t HIC_LAST  = `BSQ_CNT_W'(HICCUP_CYCLES);
  localparam bsq_pkg::bsq_cnt_t PG_LAST   = `BSQ_CNT_W'(PG_DELAY - 1);
  localparam bsq_pkg::bsq_cnt_t TMO       = `BSQ_CNT_W'(SYNC_TMO);
  localparam bsq_pkg::bsq_cnt_t CNT_MAX   = '1;

  bsq_pkg::bsq_st_t r_reg;   // registered state
  bsq_pkg::bsq_st_t r_next;  // its next value
  logic             edge_s;  // rising edge on external clock
  logic             por;     // supply, enable and software all good
  logic             tick;    // one switching cycle has passed
  logic             oc_hit;  // sampled over-current after blanking
  logic             run_zone;  // pre-bias or steady run

  // pulses per low-side ramp step
  // step 0 is the asynchronous start and has no count of its own
  function automatic bsq_pkg::bsq_cnt_t step_last(input logic [1:0] s);
    unique case (s)
      2'h1:    step_last = `BSQ_CNT_W'(`BSQ_STEP1_N - 1);
      2'h2:    step_last = `BSQ_CNT_W'(`BSQ_STEP2_N - 1);
      default: step_last = `BSQ_CNT_W'(`BSQ_STEP3_N - 1);
    endcase
  endfunction

  // low-side on-time allowed at a ramp step, a quarter of a cycle per step;
  // pre-bias always runs free, so the free period is the right base
  function automatic bsq_pkg::bsq_cnt_t ls_limit(input logic [1:0] s);
    ls_limit = `BSQ_CNT_W'((FREE_DIV * 32'(s)) / 4);
  endfunction

  // next-state logic of the whole block
  always_comb begin
    r_next = r_reg;
    // two flops on every asynchronous input; only the second is read
    r_next.meta   = cmp_i;
    r_next.sy     = r_reg.meta;
    r_next.sync_d = r_reg.sy.sync;
    // rising edge of the synchronised external clock
    edge_s = r_reg.sy.sync & ~r_reg.sync_d;
    por    = r_reg.sy.vcc_ok & r_reg.sy.en_ok & ~r_reg.shdn;
    run_zone = (r_reg.state == bsq_pkg::ST_PREBIAS) | (r_reg.state == bsq_pkg::ST_RUN);

    // a floating sync pin gives no edges, so the age runs out
    // the age saturates so a long quiet pin never looks fresh again
    if (edge_s) begin
      r_next.sync_age = '0;
    end else if (r_reg.sync_age != CNT_MAX) begin
      r_next.sync_age = r_reg.sync_age + 1'b1;
    end
    // trade-off: the lock waits for run, so the ramp keeps its own fixed timing
    // lock only in steady run, never during pre-bias
    r_next.ext_lock = (r_reg.sync_age < TMO) & ~r_reg.nosync
                    & (r_reg.state == bsq_pkg::ST_RUN);

    // switching cycle: external rising edge when locked, else divider
    // a phase left past the divider end by a lost lock ends its cycle at once;
    // an exact compare would wait for a full wrap of the phase counter
    tick = r_reg.ext_lock ? edge_s : (r_reg.phase >= FREE_LAST);
    if (tick || (r_reg.ext_lock && r_reg.phase == CNT_MAX)) begin
      r_next.phase = '0;
    end else begin
      r_next.phase = r_reg.phase + 1'b1;
    end

    // low-side on-time measured from the end of the high-side pulse
    // pre-bias narrows the low-side pulse by timing it from this counter
    if (r_reg.sy.pwm) begin
      r_next.ls_cnt = '0;
    end else if (r_reg.ls_cnt != CNT_MAX) begin
      r_next.ls_cnt = r_reg.ls_cnt + 1'b1;
    end

    // blanking after the low gate rises, then sample the comparator
    if (!r_reg.ls) begin
      r_next.blank = '0;
    end else if (r_reg.blank != BLANK_LAST) begin
      r_next.blank = r_reg.blank + 1'b1;
    end
    // limitation: a low-side pulse shorter than the blanking never sees the comparator
    oc_hit = r_reg.ls & (r_reg.blank == BLANK_LAST) & r_reg.sy.oc;

    // main sequencer, lockout first, then over-voltage, then thermal
    if (!por) begin
      r_next.state = bsq_pkg::ST_OFF;  // also clears the ov latch
      r_next.overcurrent_latch   = 1'b0;
      // over-voltage preempts all but lockout and its own latch
    end else if (r_reg.sy.ov && r_reg.state != bsq_pkg::ST_OFF
                 && r_reg.state != bsq_pkg::ST_OV_LATCH) begin
      r_next.state = bsq_pkg::ST_OV_HOLD;
      // a thermal trip cannot break an over-voltage hold or latch
    end else if (r_reg.sy.ot_hot && r_reg.state != bsq_pkg::ST_OFF
                 && r_reg.state != bsq_pkg::ST_THERMAL
                 && r_reg.state != bsq_pkg::ST_OV_HOLD
                 && r_reg.state != bsq_pkg::ST_OV_LATCH) begin
      r_next.state = bsq_pkg::ST_THERMAL;
    end else begin
      unique case (r_reg.state)
        bsq_pkg::ST_OFF: begin
          // lockout released: the discharge switch opens at once
          r_next.state = bsq_pkg::ST_SS_WAIT;
        end
        bsq_pkg::ST_SS_WAIT: begin
          // wait for the node to rise again after any pull-down
          if (r_reg.sy.ss_live) begin
            r_next.state     = bsq_pkg::ST_PREBIAS;
            r_next.step      = 2'h0;
            r_next.pulse_cnt = '0;
          end
        end
        bsq_pkg::ST_PREBIAS, bsq_pkg::ST_RUN: begin
          if (!r_reg.sy.ss_live) begin
            r_next.state = bsq_pkg::ST_SS_WAIT;
          end else if (oc_hit) begin
            r_next.state   = bsq_pkg::ST_HICCUP;  // also during ramp
            r_next.overcurrent_latch     = 1'b1;
            r_next.hic_cnt = '0;
          end else if (r_reg.state == bsq_pkg::ST_PREBIAS) begin
            if (r_reg.step == 2'h0) begin
              // async start until the first high-side pulse
              if (r_reg.sy.pwm) begin
                r_next.step = 2'h1;
              end
            end else if (tick) begin
              // each step ends on a whole number of switching cycles
              if (r_reg.pulse_cnt == step_last(r_reg.step)) begin
                r_next.pulse_cnt = '0;
                if (r_reg.step == 2'h3) begin
                  r_next.state = bsq_pkg::ST_RUN;  // full width
                end else begin
                  r_next.step = r_reg.step + 2'h1;
                end
              end else begin
                r_next.pulse_cnt = r_reg.pulse_cnt + 1'b1;
              end
            end
          end
        end
        bsq_pkg::ST_HICCUP: begin
          // count switching cycles with soft-start shorted
          // the discharge switch stays closed through the output logic below
          if (tick) begin
            if (r_reg.hic_cnt == HIC_LAST) begin
              r_next.overcurrent_latch   = 1'b0;
              r_next.state = bsq_pkg::ST_SS_WAIT;  // retry
            end else begin
              r_next.hic_cnt = r_reg.hic_cnt + 1'b1;
            end
          end
        end
        bsq_pkg::ST_THERMAL: begin
          // the trip level alone is not enough, the cool flag adds the hysteresis
          if (r_reg.sy.ot_cool) begin
            r_next.state = bsq_pkg::ST_SS_WAIT;
          end
        end
        bsq_pkg::ST_OV_HOLD: begin
          // low side stays on to pull the output down while over-voltage lasts
          if (!r_reg.sy.ov) begin
            r_next.state = bsq_pkg::ST_OV_LATCH;
          end
        end
        bsq_pkg::ST_OV_LATCH: begin
          r_next.state = bsq_pkg::ST_OV_LATCH;  // only lockout leaves
        end
      endcase
    end

    // driver outputs follow the next state so they align with it
    // stop states other than lockout and ST_OV_HOLD drive both low, so the switch node never floats
    r_next.oe = (r_next.state != bsq_pkg::ST_OFF);  // high-z when off
    r_next.hs = ((r_next.state == bsq_pkg::ST_PREBIAS) | (r_next.state == bsq_pkg::ST_RUN))
              & r_reg.sy.pwm;
    // the low side is gated by the loop demand so the two switches never overlap
    unique case (r_next.state)
      bsq_pkg::ST_RUN:     r_next.ls = ~r_reg.sy.pwm;
      bsq_pkg::ST_PREBIAS: r_next.ls = (r_next.step != 2'h0) & ~r_reg.sy.pwm
                                     & (r_reg.ls_cnt < ls_limit(r_next.step));
      bsq_pkg::ST_OV_HOLD: r_next.ls = 1'b1;
      default:             r_next.ls = 1'b0;
    endcase
    r_next.ssd = ~((r_next.state == bsq_pkg::ST_SS_WAIT) | (r_next.state == bsq_pkg::ST_PREBIAS)
                 | (r_next.state == bsq_pkg::ST_RUN));

    // power-good: window and soft-start level, then the delay
    // leaving the window or the run states restarts the delay from zero
    if (run_zone && r_reg.sy.ss_pg && r_reg.sy.pg_win && !r_reg.sy.ov) begin
      if (tick && !r_reg.good) begin
        if (r_reg.pg_cnt == PG_LAST) begin
          r_next.good = 1'b1;
        end else begin
          r_next.pg_cnt = r_reg.pg_cnt + 1'b1;
        end
      end
    end else begin
      r_next.good   = 1'b0;
      r_next.pg_cnt = '0;
    end

    // wishbone slave, answer one cycle after the strobe
    // a held strobe is taken again every second cycle
    r_next.ack = cyc_i & stb_i & ~r_reg.ack;
    if (cyc_i && stb_i && !r_reg.ack) begin
      r_next.rdat = '0;  // unmapped reads return zero
      if (adr_i == `BSQ_ADR_CTRL) begin
        // readback is taken here, before any write of this access lands
        r_next.rdat[`BSQ_CTRL_SHDN]   = r_reg.shdn;
        r_next.rdat[`BSQ_CTRL_NOSYNC] = r_reg.nosync;
      end else if (adr_i == `BSQ_ADR_STATUS) begin
        r_next.rdat = 32'({r_reg.sy.pg_pin, r_reg.sy.ot_hot, r_reg.ext_lock,
                           r_reg.overcurrent_latch, r_reg.good, r_reg.step, r_reg.state});
      end
    end
    // a write lands at the edge where the master sees ack high, while it still holds
    // the request; a low byte lane left out keeps the control bits as they are
    if (cyc_i && stb_i && we_i && r_reg.ack && sel_i[0] && (adr_i == `BSQ_ADR_CTRL)) begin
      r_next.shdn   = dat_i[`BSQ_CTRL_SHDN];
      r_next.nosync = dat_i[`BSQ_CTRL_NOSYNC];
    end
  end

  // one register for all state, synchronous reset to a quiet safe state
  // zero is a safe start for every field, though ssd rises and the counters run from the first edge on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hs_en_o    = r_reg.hs;
  assign ls_en_o    = r_reg.ls;
  assign drv_oe_o   = r_reg.oe;
  assign ss_dis_o   = r_reg.ssd;
  // power-good only ever pulls low; the wire's pull-up gives the high level
  assign pgood_o    = 1'b0;
  assign pgood_oe_o = ~r_reg.good;  // released to signal regulation
  assign dat_o      = r_reg.rdat;
  assign ack_o      = r_reg.ack;

  // checks on the sequencer
  // outputs are registered, so most checks look one edge after the decision
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_lockout;
    !(r_reg.sy.vcc_ok && r_reg.sy.en_ok) |=> !hs_en_o && !ls_en_o && !drv_oe_o;
  endproperty
  a_lockout: assert property (p_lockout) else $error("drivers active in lockout");

  property p_start;
    r_reg.state == bsq_pkg::ST_OFF && por |=> r_reg.state == bsq_pkg::ST_SS_WAIT && !ss_dis_o;
  endproperty
  a_start: assert property (p_start) else $error("soft-start did not begin");

  property p_async;
    r_reg.state == bsq_pkg::ST_PREBIAS && r_reg.step == 2'h0 |-> !ls_en_o;
  endproperty
  a_async: assert property (p_async) else $error("low side before first pulse");

  property p_step2;
    $changed(r_reg.step) && r_reg.step == 2'h2 |-> $past(r_reg.pulse_cnt) == `BSQ_STEP1_N - 1;
  endproperty
  a_step2: assert property (p_step2) else $error("first step wrong length");

  property p_blank;
    $rose(r_reg.overcurrent_latch) |-> $past(r_reg.ls) && $past(r_reg.blank) == BLANK_LAST;
  endproperty
  a_blank: assert property (p_blank) else $error("over-current sampled in blanking");

  property p_hiccup;
    $rose(r_reg.overcurrent_latch) |-> r_reg.state == bsq_pkg::ST_HICCUP && ss_dis_o && !hs_en_o;
  endproperty
  a_hiccup: assert property (p_hiccup) else $error("hiccup not entered");

  property p_ovhold;
    r_reg.state == bsq_pkg::ST_OV_HOLD |-> !hs_en_o && ls_en_o;
  endproperty
  a_ovhold: assert property (p_ovhold) else $error("wrong drive in over-voltage");

  property p_ovlatch;
    r_reg.state == bsq_pkg::ST_OV_LATCH && por |=> r_reg.state == bsq_pkg::ST_OV_LATCH;
  endproperty
  a_ovlatch: assert property (p_ovlatch) else $error("over-voltage latch released");

  property p_pgood;
    $fell(pgood_oe_o) |-> $past(r_reg.pg_cnt) == PG_LAST && $past(r_reg.sy.ss_pg);
  endproperty
  a_pgood: assert property (p_pgood) else $error("power-good released early");

  property p_thermal;
    r_reg.state == bsq_pkg::ST_THERMAL |-> ss_dis_o && !hs_en_o && !ls_en_o;
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal stop incomplete");

  property p_ssdown;
    (r_reg.state == bsq_pkg::ST_PREBIAS || r_reg.state == bsq_pkg::ST_RUN) && !r_reg.sy.ss_live
      |=> r_reg.state != bsq_pkg::ST_PREBIAS && r_reg.state != bsq_pkg::ST_RUN;
  endproperty
  a_ssdown: assert property (p_ssdown) else $error("switching went on with soft-start low");

  property p_lockrun;
    r_reg.ext_lock |-> $past(r_reg.state) == bsq_pkg::ST_RUN;
  endproperty
  a_lockrun: assert property (p_lockrun) else $error("external clock used before run");

  property p_hicoff;
    r_reg.state == bsq_pkg::ST_HICCUP |-> ss_dis_o && !hs_en_o && !ls_en_o && r_reg.overcurrent_latch;
  endproperty
  a_hicoff: assert property (p_hicoff) else $error("hiccup without discharge");

  property p_window;
    !r_reg.sy.pg_win |=> pgood_oe_o;
  endproperty
  a_window: assert property (p_window) else $error("power-good outside window");

  c_hiccup: cover property (r_reg.state == bsq_pkg::ST_HICCUP ##1 r_reg.state == bsq_pkg::ST_SS_WAIT);
  c_run:    cover property ($fell(pgood_oe_o));
  c_lock:   cover property ($rose(r_reg.ext_lock));
  c_ovl:    cover property (r_reg.state == bsq_pkg::ST_OV_LATCH);
  c_therm:  cover property (r_reg.state == bsq_pkg::ST_THERMAL ##1 r_reg.state == bsq_pkg::ST_SS_WAIT);
endmodule
`default_nettype wire

/* File: verification/bsq_partner.sv */
// partner model: system logic that drives enable and sync and pulls power-good up
`timescale 1ns/1ps
`default_nettype none
module bsq_partner #(
  parameter int SYNC_HALF = 3  // clk per half period of the external clock
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic en_req_i,    // system wants the regulator on
  input  wire logic sync_on_i,   // external clock applied
  input  wire logic pgood_oe_i,  // device pulls power-good low
  output logic      en_ok_o,     // enable pin above its threshold
  output logic      sync_o,      // external clock level
  output logic      pg_pin_o     // resolved power-good wire
);
  int cnt;  // half-period counter
  // enable follows the request; low means below 1 V, which also recycles a latch
  always_ff @(posedge clk_i) begin
    en_ok_o <= en_req_i;
  end
  // external clock toggles while applied, stands low when left open
  always_ff @(posedge clk_i) begin
    if (rst_i || !sync_on_i) begin
      cnt    <= 0;
      sync_o <= 1'b0;
    end else if (cnt == SYNC_HALF - 1) begin
      cnt    <= 0;
      sync_o <= ~sync_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // pull-up resistor: a released wire reads high
  assign pg_pin_o = pgood_oe_i ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: verification/bsq_sequencer_tb_top.sv */
// self-checking bench of the start-up and fault sequencer
`timescale 1ns/1ps
`default_nettype none
`include "bsq_defs.svh"
module bsq_sequencer_tb_top;
  localparam int FD  = 8;  // clk per free-running switching cycle
  localparam int HC  = 4;  // shortened hiccup count
  localparam int PGD = 4;  // shortened power-good delay
  localparam int SP  = 6;  // clk per sync period
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [7:0]        adr = 8'h00;
  logic [31:0]       wdat = 32'h0;
  logic [3:0]        sel = 4'h0;
  logic              we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic              en_req = 1'b0, sync_on = 1'b0, pwm_run = 1'b0;
  logic              pwm_lvl = 1'b0;  // loop demand level, one driver only
  logic [31:0]       dat_o, q;
  logic              ack_o, hs, ls, drv_oe, ss_dis, pgood, pgood_oe, en_ok, sync, pg_pin;
  bsq_pkg::bsq_cmp_t cmpr = '0;  // comparator levels the bench drives
  bsq_pkg::bsq_cmp_t cmp;        // same, with the partner's pins merged in
  int                fail_count = 0, checks_done = 0, pcnt = 0, tick = 0;
  int                seed, n, k, run, shorts, t0, ctrl_model;
  always #20 clk_i = ~clk_i;
  always_comb begin
    cmp        = cmpr;
    cmp.pwm    = pwm_lvl;
    cmp.en_ok  = en_ok;
    cmp.sync   = sync;
    cmp.pg_pin = pg_pin;
  end
  // loop demand: high 3 of every FD clk while regulating
  always @(posedge clk_i) begin
    pcnt     <= (pcnt + 1) % FD;
    tick     <= tick + 1;
    pwm_lvl  <= pwm_run && (pcnt < 3);
  end
  bsq_sequencer #(.FREE_DIV(FD), .HICCUP_CYCLES(HC), .PG_DELAY(PGD), .SYNC_TMO(2 * SP)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cmp_i(cmp), .adr_i(adr), .dat_i(wdat), .sel_i(sel),
    .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(dat_o), .ack_o(ack_o), .hs_en_o(hs),
    .ls_en_o(ls), .drv_oe_o(drv_oe), .ss_dis_o(ss_dis), .pgood_o(pgood), .pgood_oe_o(pgood_oe));
  bsq_partner #(.SYNC_HALF(SP / 2)) PARTNER (
    .clk_i(clk_i), .rst_i(rst_i), .en_req_i(en_req), .sync_on_i(sync_on),
    .pgood_oe_i(pgood_oe), .en_ok_o(en_ok), .sync_o(sync), .pg_pin_o(pg_pin));
  task automatic summarize;
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  // one classic wishbone cycle; holds everything until ack is sampled
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge clk_i);
    adr  <= a;
    we   <= w;
    wdat <= d;
    sel  <= s;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && i < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (i >= 20) begin
      check(1'b0, "bus answer missing");
      summarize();
    end
  endtask
  // poll status until the masked bits match; bounded
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int i;
    i = 0;
    do begin
      wb(`BSQ_ADR_STATUS, 1'b0, 32'h0, 4'hf);
      i++;
    end while ((q & m) !== v && i < 400);
    check(i < 400, "status never reached");
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return ss_dis;
      1: return hs;
      2: return ls;
      3: return pgood_oe;
      default: return drv_oe;
    endcase
  endfunction
  // wait for an output level, counting clocks into n
  task automatic await(input int w, input logic lvl, input int bound);
    n = 0;
    while (pick(w) !== lvl && n < bound) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= bound) begin
      check(1'b0, "output wait ran out");
      summarize();
    end
  endtask
  // an output must keep its level for cnt clocks
  task automatic hold(input int w, input logic lvl, input int cnt);
    k = 0;
    repeat (cnt) begin
      @(posedge clk_i);
      if (pick(w) !== lvl) k++;
    end
    check(k == 0, "output left its level");
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    check(1'b0, "run too long");
    summarize();
  end
  initial begin
    seed = 32'h6b194f2a;
    ctrl_model = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(drv_oe === 1'b0 && hs === 1'b0 && ls === 1'b0, "drivers not off");
    check(pgood_oe === 1'b1 && pgood === 1'b0, "power-good not pulled low");
    wb(`BSQ_ADR_CTRL, 1'b0, 32'h0, 4'hf);
    check(q === ctrl_model, "control reset value");
    wb(8'h10, 1'b1, $random(seed), 4'hf);
    wb(8'h10, 1'b0, 32'h0, 4'hf);
    check(q === 32'h0, "unmapped read not zero");
    wb(`BSQ_ADR_STATUS, 1'b1, $random(seed), 4'hf);
    wb(`BSQ_ADR_STATUS, 1'b0, 32'h0, 4'hf);
    check(q[2:0] === 3'h0, "not off in lockout");
    // start-up with the external clock already applied
    sync_on <= 1'b1;
    en_req <= 1'b1;
    pwm_run <= 1'b1;
    cmpr.vcc_ok <= 1'b1;
    cmpr.ss_live <= 1'b1;
    await(0, 1'b0, 50);
    k = 0;
    while (hs !== 1'b1 && k < 200) begin
      @(posedge clk_i);
      k++;
      if (ls === 1'b1) check(1'b0, "low side before first high pulse");
    end
    t0 = tick;
    shorts = 0;
    run = 0;
    k = 0;
    while (k < 1000) begin
      @(posedge clk_i);
      k++;
      if (ls === 1'b1) begin
        run++;
      end else begin
        if (run > FD / 4) break;
        if (run > 0) shorts++;
        run = 0;
      end
    end
    check(shorts >= 31 && shorts <= 33, "quarter-width pulse count");
    wb(`BSQ_ADR_STATUS, 1'b0, 32'h0, 4'hf);
    check(q[4:0] === 5'h12 && q[7] === 1'b0, "second step or early lock");
    poll(32'h7, 32'h3);
    check(tick - t0 >= 54 * FD, "ramp ended early");
    poll(32'h80, 32'h80);
    // power-good: soft-start level, window and delay
    cmpr.pg_win <= 1'b1;
    hold(3, 1'b1, 60);
    cmpr.pg_win <= 1'b0;
    cmpr.ss_pg <= 1'b1;
    hold(3, 1'b1, 30);
    cmpr.pg_win <= 1'b1;
    await(3, 1'b0, 200);
    check(n >= (PGD - 1) * SP && n <= (PGD + 2) * SP + 4, "power-good delay");
    poll(32'h220, 32'h220);
    cmpr.pg_win <= 1'b0;
    await(3, 1'b1, 10);
    sync_on <= 1'b0;
    poll(32'h80, 32'h0);
    // over-current: hiccup, repeat, blanking
    cmpr.oc <= 1'b1;
    await(0, 1'b1, 100);
    t0 = tick;
    poll(32'h47, 32'h44);
    await(0, 1'b0, 200);
    check(tick - t0 >= HC * FD && tick - t0 <= (HC + 2) * FD, "hiccup length");
    t0 = tick;
    await(0, 1'b1, 1000);
    check(tick - t0 >= 31 * FD, "trip inside blanking");
    cmpr.oc <= 1'b0;
    await(0, 1'b0, 200);
    poll(32'h7, 32'h3);
    // thermal trip and cool-down restart
    cmpr.ot_hot <= 1'b1;
    await(0, 1'b1, 10);
    check(hs === 1'b0 && ls === 1'b0, "switches on while hot");
    cmpr.ot_hot <= 1'b0;
    hold(0, 1'b1, 30);
    cmpr.ot_cool <= 1'b1;
    await(0, 1'b0, 10);
    cmpr.ot_cool <= 1'b0;
    poll(32'h7, 32'h3);
    // soft-start node pulled low stops switching until it rises again
    cmpr.ss_live <= 1'b0;
    repeat (5) @(posedge clk_i);
    hold(1, 1'b0, 40);
    cmpr.ss_live <= 1'b1;
    await(1, 1'b1, 100);
    // over-voltage: low side on, then latched off until enable recycles
    cmpr.ov <= 1'b1;
    repeat (5) @(posedge clk_i);
    check(hs === 1'b0 && ls === 1'b1, "over-voltage drive");
    hold(2, 1'b1, 20);
    cmpr.ov <= 1'b0;
    repeat (5) @(posedge clk_i);
    check(hs === 1'b0 && ls === 1'b0 && drv_oe === 1'b1, "latch-off");
    hold(1, 1'b0, 60);
    en_req <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(drv_oe === 1'b0 && hs === 1'b0 && ls === 1'b0, "enable low not high-z");
    en_req <= 1'b1;
    await(0, 1'b0, 50);
    // software shutdown through the control register
    wb(`BSQ_ADR_CTRL, 1'b1, 32'h1, 4'he);
    wb(`BSQ_ADR_CTRL, 1'b0, 32'h0, 4'hf);
    check(q === ctrl_model, "masked write took effect");
    ctrl_model = 1;
    wb(`BSQ_ADR_CTRL, 1'b1, ctrl_model, 4'hf);
    repeat (5) @(posedge clk_i);
    check(drv_oe === 1'b0, "shutdown ignored");
    ctrl_model = 2;
    wb(`BSQ_ADR_CTRL, 1'b1, ctrl_model, 4'hf);
    wb(`BSQ_ADR_CTRL, 1'b0, 32'h0, 4'hf);
    check(q === ctrl_model, "control readback");
    await(0, 1'b0, 50);
    summarize();
  end
endmodule
`default_nettype wire
